// ---- logic/fetch_timing_pkg.sv ----
// Constants and types for the instruction fetch and execute timing block
package fetch_timing_pkg;

    // ********************************************************************
    // Clock and widths
    // ********************************************************************
    localparam int CLK_PERIOD_NS  = 50;
    localparam int PC_W           = 12;
    localparam int WORD_W         = 16;
    localparam int DATA_W         = 8;
    localparam int HOLD_W         = 20;
    localparam int QUAL_W         = 13;
    localparam int WAIT_W         = 11;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [11:0] PC_RESET    = 12'h000;
    localparam logic [3:0]  PHASE_IDLE  = 4'h0;
    localparam logic [3:0]  PHASE_FIRST = 4'h1;

    // ********************************************************************
    // Times in their own units
    // ********************************************************************
    localparam int HOLDOFF_LONG_MS    = 50;
    localparam int HOLDOFF_SHORT_NS   = 16_700_000;
    localparam int LOWV_RST_QUAL_US   = 240;
    localparam int LOWV_DET_QUAL_US   = 45;
    localparam int SWRST_QUAL_US      = 90;
    localparam int STARTUP_FAST_TSYS  = 1024;
    localparam int STARTUP_SLOW_TSYS  = 2;
    localparam int WAKE_RUN_TSYS      = 2;

    // ********************************************************************
    // Times in clock cycles
    // ********************************************************************
    localparam int HOLDOFF_LONG_CYC  = HOLDOFF_LONG_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int HOLDOFF_SHORT_CYC = HOLDOFF_SHORT_NS / CLK_PERIOD_NS;
    localparam int LOWV_RST_QUAL_CYC = LOWV_RST_QUAL_US * 1000 / CLK_PERIOD_NS;
    localparam int LOWV_DET_QUAL_CYC = LOWV_DET_QUAL_US * 1000 / CLK_PERIOD_NS;
    localparam int SWRST_QUAL_CYC    = SWRST_QUAL_US * 1000 / CLK_PERIOD_NS;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        ST_HOLDOFF = 2'b00,
        ST_WAIT    = 2'b01,
        ST_RUN     = 2'b10,
        ST_HALT    = 2'b11
    } run_state_t;

    typedef enum logic [3:0] {
        ALU_ADD  = 4'h0,
        ALU_ADC  = 4'h1,
        ALU_SUB  = 4'h2,
        ALU_AND  = 4'h3,
        ALU_OR   = 4'h4,
        ALU_XOR  = 4'h5,
        ALU_CPL  = 4'h6,
        ALU_RR   = 4'h7,
        ALU_RL   = 4'h8,
        ALU_RRC  = 4'h9,
        ALU_RLC  = 4'hA,
        ALU_INC  = 4'hB,
        ALU_DEC  = 4'hC,
        ALU_LOAD = 4'hD
    } alu_op_t;

endpackage : fetch_timing_pkg

// ---- logic/mcu_fetch_execute_timing.sv ----
// Instruction phase, pipeline, start-up and reset hold-off control
`timescale 1ns/100ps

// Behaviour
// RULE1: Four one-hot non-overlapping phases rotate, and one full rotation is one instruction cycle.
// RULE2: At the start of the first phase the program counter advances and that phase fetches the word.
// RULE3: Decode and execution of an instruction fall in phases two to four of its cycle.
// RULE4: The next fetch overlaps the current execution, giving one instruction per cycle.
// RULE5: An instruction that loads the program counter costs one extra cycle, two in total.
// RULE6: A branch takes its target in its first cycle, drops the prefetched word and fetches the target next.
// RULE7: Arithmetic, logic, rotate, step and decision operations use an 8-bit unit on the accumulator.
// RULE8: After a stopped-clock halt or slow-to-normal switch wait 1024 periods on fast, 2 on slow oscillator.
// RULE9: Waking from halt with the clock running waits two periods before resuming.
// RULE10: Power-on, low-voltage and software resets hold execution off for 50 ms.
// RULE11: Any other reset holds execution off for 16.7 ms.
// RULE12: A low supply causes a low-voltage reset only after persisting 240 us.
// RULE13: A low supply raises the low-voltage detect interrupt after persisting 45 us.
// RULE14: A software reset request takes effect after 90 us.
// RULE15: After any reset the program counter is zero and execution starts there.
// RULE16: Phases restart at the first phase whenever a hold-off or start-up wait ends.
module mcu_fetch_execute_timing #(
    parameter int HOLDOFF_LONG_CYC  = fetch_timing_pkg::HOLDOFF_LONG_CYC,
    parameter int HOLDOFF_SHORT_CYC = fetch_timing_pkg::HOLDOFF_SHORT_CYC,
    parameter int LOWV_RST_QUAL_CYC = fetch_timing_pkg::LOWV_RST_QUAL_CYC
) (
    input  wire logic                                clk_in,
    input  wire logic                                nrst_in,
    input  wire logic                                osc_slow_sel_in,
    input  wire logic                                halt_in,
    input  wire logic                                wake_in,
    input  wire logic                                clk_stop_in,
    input  wire logic                                slow_to_normal_in,
    input  wire logic                                branch_in,
    input  wire logic [fetch_timing_pkg::PC_W-1:0]   branch_target_in,
    input  wire logic [fetch_timing_pkg::WORD_W-1:0] instr_word_in,
    input  wire logic                                alu_en_in,
    input  wire fetch_timing_pkg::alu_op_t           alu_op_in,
    input  wire logic [fetch_timing_pkg::DATA_W-1:0] operand_in,
    input  wire logic                                low_supply_in,
    input  wire logic                                ext_rst_n_in,
    input  wire logic                                sw_reset_req_in,
    output logic      [3:0]                          instruction_phase_clocks_out,
    output logic                                     fetch_strobe_out,
    output logic      [fetch_timing_pkg::PC_W-1:0]   fetch_addr_out,
    output logic      [fetch_timing_pkg::WORD_W-1:0] exec_word_out,
    output logic                                     exec_valid_out,
    output logic                                     flush_out,
    output logic      [fetch_timing_pkg::DATA_W-1:0] acc_out,
    output logic                                     carry_out,
    output logic                                     zero_out,
    output logic                                     low_voltage_detect_irq_out
);
    import fetch_timing_pkg::*;

    // ********************************************************************
    // Declarations
    // ********************************************************************
    run_state_t          state_ff;
    logic [3:0]          phase_ff;
    logic [PC_W-1:0]     pc_ff;
    logic [PC_W-1:0]     fetch_addr_ff;
    logic [WORD_W-1:0]   fetch_word_ff;
    logic                fetch_valid_ff;
    logic [WORD_W-1:0]   exec_word_ff;
    logic                exec_valid_ff;
    logic                flush_ff;
    logic [DATA_W-1:0]   acc_ff;
    logic                carry_ff;
    logic                zero_ff;
    logic [HOLD_W-1:0]   hold_cnt_ff;
    logic [WAIT_W-1:0]   wait_cnt_ff;
    logic [2:0]          low_sync_ff;
    logic [2:0]          ext_sync_ff;
    logic                low_lvl_ff;
    logic                ext_lvl_ff;
    logic [QUAL_W-1:0]   low_cnt_ff;
    logic [QUAL_W-1:0]   sw_cnt_ff;
    logic                sw_pend_ff;
    logic                lowv_det_irq_ff;
    logic [DATA_W:0]     nxt_alu;
    logic                lowv_rst_hit;
    logic                sw_hit;
    logic                long_rst;
    logic                short_rst;
    logic                start_run;
    logic                br_now;
    logic                pause;
    logic                boundary;
    logic                advance;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic logic [DATA_W:0] alu_calc(alu_op_t op, logic [DATA_W-1:0] a,
                                                 logic [DATA_W-1:0] b, logic c);
        unique case (op)
            ALU_ADD:  alu_calc = {1'b0, a} + {1'b0, b};
            ALU_ADC:  alu_calc = {1'b0, a} + {1'b0, b} + {8'h00, c};
            ALU_SUB:  alu_calc = {1'b0, a} + {1'b0, ~b} + 9'h001;
            ALU_AND:  alu_calc = {c, a & b};
            ALU_OR:   alu_calc = {c, a | b};
            ALU_XOR:  alu_calc = {c, a ^ b};
            ALU_CPL:  alu_calc = {c, ~a};
            ALU_RR:   alu_calc = {c, a[0], a[7:1]};
            ALU_RL:   alu_calc = {c, a[6:0], a[7]};
            ALU_RRC:  alu_calc = {a[0], c, a[7:1]};
            ALU_RLC:  alu_calc = {a[7], a[6:0], c};
            ALU_INC:  alu_calc = {c, a + 8'h01};
            ALU_DEC:  alu_calc = {c, a - 8'h01};
            ALU_LOAD: alu_calc = {c, b};
            default:  alu_calc = {c, a};
        endcase
    endfunction : alu_calc

    function automatic logic [WAIT_W-1:0] startup_count(logic stopped, logic slow);
        if (!stopped) begin
            startup_count = WAIT_W'(WAKE_RUN_TSYS - 1);
        end else if (slow) begin
            startup_count = WAIT_W'(STARTUP_SLOW_TSYS - 1);
        end else begin
            startup_count = WAIT_W'(STARTUP_FAST_TSYS - 1);
        end
    endfunction : startup_count

    // ********************************************************************
    // Reset sources and qualification
    // ********************************************************************
    assign lowv_rst_hit = low_lvl_ff && (low_cnt_ff == QUAL_W'(LOWV_RST_QUAL_CYC - 1)); // [RULE12]
    assign sw_hit       = sw_pend_ff && (sw_cnt_ff == QUAL_W'(SWRST_QUAL_CYC - 1)); // [RULE14]
    assign long_rst     = lowv_rst_hit || sw_hit;
    assign short_rst    = !ext_lvl_ff;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            low_sync_ff <= 3'h0;
            ext_sync_ff <= 3'h7;
            low_lvl_ff  <= 1'b0;
            ext_lvl_ff  <= 1'b1;
        end else begin
            low_sync_ff <= {low_sync_ff[1:0], low_supply_in};
            ext_sync_ff <= {ext_sync_ff[1:0], ext_rst_n_in};
            if (low_sync_ff[1] == low_sync_ff[2]) begin
                low_lvl_ff <= low_sync_ff[2];
            end
            if (ext_sync_ff[1] == ext_sync_ff[2]) begin
                ext_lvl_ff <= ext_sync_ff[2];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in || !low_lvl_ff) begin
            low_cnt_ff      <= '0;
            lowv_det_irq_ff <= 1'b0;
        end else begin
            if (!lowv_rst_hit) begin
                low_cnt_ff <= low_cnt_ff + 13'h0001;
            end
            lowv_det_irq_ff <= (low_cnt_ff == QUAL_W'(LOWV_DET_QUAL_CYC - 1)); // [RULE13]
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sw_pend_ff <= 1'b0;
            sw_cnt_ff  <= '0;
        end else if (sw_reset_req_in) begin
            sw_pend_ff <= 1'b1;
            sw_cnt_ff  <= (sw_pend_ff && !sw_hit) ? sw_cnt_ff + 13'h0001 : '0;
        end else if (sw_hit) begin
            sw_pend_ff <= 1'b0;
            sw_cnt_ff  <= '0;
        end else if (sw_pend_ff) begin
            sw_cnt_ff  <= sw_cnt_ff + 13'h0001;
        end
    end

    // ********************************************************************
    // Run state, hold-off and start-up waits
    // ********************************************************************
    assign start_run = !long_rst && !short_rst &&
                       (((state_ff == ST_HOLDOFF) && (hold_cnt_ff == '0)) ||
                        ((state_ff == ST_WAIT) && (wait_cnt_ff == '0)));
    assign br_now    = (state_ff == ST_RUN) && phase_ff[3] && exec_valid_ff && branch_in;
    assign pause     = (state_ff == ST_RUN) && phase_ff[3] && !br_now &&
                       (halt_in || slow_to_normal_in);
    assign boundary  = (state_ff == ST_RUN) && phase_ff[3] && !pause;
    assign advance   = boundary || start_run;

    always_ff @(posedge clk_in) begin
        if (!nrst_in || long_rst) begin
            state_ff    <= ST_HOLDOFF;
            hold_cnt_ff <= HOLD_W'(HOLDOFF_LONG_CYC - 1); // [RULE10]
            wait_cnt_ff <= '0;
        end else if (short_rst) begin
            state_ff    <= ST_HOLDOFF;
            hold_cnt_ff <= HOLD_W'(HOLDOFF_SHORT_CYC - 1); // [RULE11]
        end else begin
            unique case (state_ff)
                ST_HOLDOFF: begin
                    if (hold_cnt_ff == '0) begin
                        state_ff <= ST_RUN;
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff - 20'h00001;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt_ff == '0) begin
                        state_ff <= ST_RUN;
                    end else begin
                        wait_cnt_ff <= wait_cnt_ff - 11'h001;
                    end
                end
                ST_RUN: begin
                    if (pause && halt_in) begin
                        state_ff <= ST_HALT;
                    end else if (pause) begin
                        state_ff    <= ST_WAIT;
                        wait_cnt_ff <= startup_count(1'b1, 1'b0); // [RULE8]
                    end
                end
                ST_HALT: begin
                    if (wake_in) begin
                        state_ff    <= ST_WAIT;
                        wait_cnt_ff <= startup_count(clk_stop_in, osc_slow_sel_in); // [RULE8] [RULE9]
                    end
                end
            endcase
        end
    end

    // ********************************************************************
    // Phase generation
    // ********************************************************************
    always_ff @(posedge clk_in) begin
        if (!nrst_in || long_rst || short_rst) begin
            phase_ff <= PHASE_IDLE;
        end else if (start_run) begin
            phase_ff <= PHASE_FIRST; // [RULE16]
        end else if (pause) begin
            phase_ff <= PHASE_IDLE;
        end else if (state_ff == ST_RUN) begin
            phase_ff <= {phase_ff[2:0], phase_ff[3]}; // [RULE1]
        end
    end

    // ********************************************************************
    // Fetch and execute pipeline
    // ********************************************************************
    always_ff @(posedge clk_in) begin
        if (!nrst_in || long_rst || short_rst) begin
            pc_ff          <= PC_RESET; // [RULE15]
            fetch_addr_ff  <= PC_RESET;
            fetch_word_ff  <= '0;
            fetch_valid_ff <= 1'b0;
            exec_word_ff   <= '0;
            exec_valid_ff  <= 1'b0;
            flush_ff       <= 1'b0;
        end else if (advance && br_now) begin
            fetch_addr_ff  <= branch_target_in; // [RULE6]
            pc_ff          <= branch_target_in + 12'h001;
            fetch_valid_ff <= 1'b0;
            exec_valid_ff  <= 1'b0; // [RULE5]
            flush_ff       <= 1'b1;
        end else if (advance) begin
            fetch_addr_ff  <= pc_ff; // [RULE2]
            pc_ff          <= pc_ff + 12'h001;
            exec_word_ff   <= fetch_word_ff; // [RULE4]
            exec_valid_ff  <= fetch_valid_ff;
            fetch_valid_ff <= 1'b0;
            flush_ff       <= 1'b0;
        end else if (pause) begin
            exec_valid_ff  <= 1'b0;
            flush_ff       <= 1'b0;
        end else if ((state_ff == ST_RUN) && phase_ff[0]) begin
            fetch_word_ff  <= instr_word_in; // [RULE2]
            fetch_valid_ff <= 1'b1;
        end
    end

    // ********************************************************************
    // Arithmetic unit on the accumulator
    // ********************************************************************
    assign nxt_alu = alu_calc(alu_op_in, acc_ff, operand_in, carry_ff);

    always_ff @(posedge clk_in) begin
        if (!nrst_in || long_rst || short_rst) begin
            acc_ff   <= '0;
            carry_ff <= 1'b0;
            zero_ff  <= 1'b1;
        end else if ((state_ff == ST_RUN) && phase_ff[3] && exec_valid_ff && alu_en_in) begin
            acc_ff   <= nxt_alu[DATA_W-1:0]; // [RULE3] [RULE7]
            carry_ff <= nxt_alu[DATA_W];
            zero_ff  <= (nxt_alu[DATA_W-1:0] == 8'h00);
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign instruction_phase_clocks_out = phase_ff;
    assign fetch_strobe_out             = phase_ff[0];
    assign fetch_addr_out               = fetch_addr_ff;
    assign exec_word_out                = exec_word_ff;
    assign exec_valid_out               = exec_valid_ff;
    assign flush_out                    = flush_ff;
    assign acc_out                      = acc_ff;
    assign carry_out                    = carry_ff;
    assign zero_out                     = zero_ff;
    assign low_voltage_detect_irq_out   = lowv_det_irq_ff;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    sequence branch_taken_s;
        br_now && !long_rst && !short_rst;
    endsequence

    sequence flush_cycle_s;
        flush_ff && !exec_valid_ff ##3 flush_ff ##1 !flush_ff;
    endsequence

    AST_PHASE_ONEHOT: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE1]
        (state_ff == ST_RUN) |-> $onehot(phase_ff))
        else $error("phase clocks not one-hot while running");
    AST_PHASE_CYCLE: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE1]
        (phase_ff[0] && state_ff == ST_RUN && !long_rst && !short_rst)
        |=> phase_ff[1] ##1 phase_ff[2] ##1 phase_ff[3])
        else $error("phase sequence broken");
    AST_PC_ADVANCE: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE2]
        $rose(phase_ff[0]) |-> (pc_ff == fetch_addr_ff + 12'h001))
        else $error("program counter did not advance at first phase");
    AST_ALU_T4_ONLY: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE3]
        (!$stable(acc_ff) && !$past(long_rst) && !$past(short_rst)) |-> $past(phase_ff[3]))
        else $error("accumulator changed outside last phase");
    AST_OVERLAP: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE4]
        (boundary && !br_now && fetch_valid_ff && !long_rst && !short_rst)
        |=> exec_valid_ff && (exec_word_ff == $past(fetch_word_ff)))
        else $error("fetched word not passed to execution");
    AST_BRANCH_FLUSH: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE6]
        branch_taken_s |=> (fetch_addr_ff == $past(branch_target_in)) && flush_ff)
        else $error("branch did not fetch target with flush");
    AST_BRANCH_TWO_CYCLES: assert property (@(posedge clk_in) // [RULE5]
        disable iff (!nrst_in || long_rst || short_rst)
        branch_taken_s |=> flush_cycle_s)
        else $error("branch did not cost exactly one dummy cycle");
    AST_RESET_PC: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE15]
        ($past(state_ff) == ST_HOLDOFF && $rose(phase_ff[0])) |-> (fetch_addr_ff == PC_RESET))
        else $error("first fetch after reset not at address zero");
    AST_START_T1: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE16]
        start_run |=> (phase_ff == PHASE_FIRST))
        else $error("phases did not restart at first phase");
    AST_LOWV_DET_WIDTH: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE13]
        $rose(lowv_det_irq_ff) |-> $past(low_cnt_ff) == QUAL_W'(LOWV_DET_QUAL_CYC - 1))
        else $error("low voltage detect raised at wrong width");
    AST_WAKE_WAIT: assert property (@(posedge clk_in) disable iff (!nrst_in) // [RULE9]
        (state_ff == ST_HALT && wake_in && !clk_stop_in && !long_rst && !short_rst)
        |=> (state_ff == ST_WAIT) ##1 (state_ff == ST_WAIT))
        else $error("wake with running clock did not wait two periods");

endmodule : mcu_fetch_execute_timing

// ---- verif/tb_mcu_fetch_execute_timing.sv ----
// Self-checking testbench for the instruction timing block
`timescale 1ns/100ps
module tb_mcu_fetch_execute_timing;
    import fetch_timing_pkg::*;
    // ********************************************************************
    // Signals
    // ********************************************************************
    logic          clk_in, nrst_in, osc_slow, halt, wake, clk_stop, s2n, branch;
    logic          alu_en, low_sup, ext_n, swr, fstb, xval, flush, cy, zr, irq;
    logic [11:0]   target, faddr;
    logic [15:0]   instr_word, xword;
    logic [7:0]    operand, acc;
    logic [3:0]    ph;
    alu_op_t       op;
    int            n_mismatch = 0;
    int            cmp_count = 0;
    int            n;

    mcu_fetch_execute_timing #(.HOLDOFF_LONG_CYC(40), .HOLDOFF_SHORT_CYC(20),
        .LOWV_RST_QUAL_CYC(1000)) dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .osc_slow_sel_in(osc_slow), .halt_in(halt),
        .wake_in(wake), .clk_stop_in(clk_stop), .slow_to_normal_in(s2n),
        .branch_in(branch), .branch_target_in(target), .instr_word_in(instr_word),
        .alu_en_in(alu_en), .alu_op_in(op), .operand_in(operand),
        .low_supply_in(low_sup), .ext_rst_n_in(ext_n), .sw_reset_req_in(swr),
        .instruction_phase_clocks_out(ph), .fetch_strobe_out(fstb),
        .fetch_addr_out(faddr), .exec_word_out(xword), .exec_valid_out(xval),
        .flush_out(flush), .acc_out(acc), .carry_out(cy), .zero_out(zr),
        .low_voltage_detect_irq_out(irq));

    // ********************************************************************
    // Clock, program memory and helpers
    // ********************************************************************
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(negedge clk_in) instr_word <= {4'h5, faddr};

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_ph(input logic [3:0] p, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk_in);
            cnt++;
        end while (ph !== p && cnt < 5000);
    endtask : wait_ph

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // ********************************************************************
    // Scenarios
    // ********************************************************************
    task automatic t_pipe();
        logic [11:0] a;
        a = faddr;
        for (int i = 0; i < 8; i++) begin
            check(ph, 32'h1 << (i % 4));
            check(fstb, (i % 4) == 0);
            @(negedge clk_in);
        end
        check(faddr, a + 12'h002);
        check({xval, xword}, {1'b1, 4'h5, a + 12'h001});
    endtask : t_pipe

    task automatic t_alu_branch();
        wait_ph(4'h8, n);
        {alu_en, operand} = {1'b1, 8'h3C};
        op = ALU_LOAD;
        wait_ph(4'h8, n);
        check(acc, 8'h3C);
        op = ALU_ADD;
        operand = 8'hD0;
        wait_ph(4'h8, n);
        check({acc, cy, zr}, {8'h0C, 1'b1, 1'b0});
        {alu_en, branch, target} = {1'b0, 1'b1, 12'h123};
        wait_ph(4'h1, n);
        branch = 1'b0;
        check({flush, xval, faddr}, {2'b10, 12'h123});
        wait_ph(4'h1, n);
        check({flush, xval, faddr}, {2'b01, 12'h124});
        check(xword, {4'h5, 12'h123});
    endtask : t_alu_branch

    task automatic t_halt(input logic use_s2n, input logic stop, input logic slow,
                          input int min);
        wait_ph(4'h8, n);
        {s2n, halt, clk_stop, osc_slow} = {use_s2n, !use_s2n, stop, slow};
        wait_ph(4'h0, n);
        {s2n, halt} = 2'b00;
        if (!use_s2n) begin
            repeat (3) @(negedge clk_in);
            wake = 1'b1;
            @(negedge clk_in);
            wake = 1'b0;
        end
        wait_ph(4'h1, n);
        check(n >= min && n <= min + 8, 1);
    endtask : t_halt

    task automatic t_resets();
        ext_n = 1'b0;
        repeat (10) @(negedge clk_in);
        ext_n = 1'b1;
        wait_ph(4'h1, n);
        check(n >= 20 && n < 40, 1);
        check(faddr, 12'h000);
        swr = 1'b1;
        @(negedge clk_in);
        swr = 1'b0;
        wait_ph(4'h0, n);
        check(n >= 1795 && n <= 1805, 1);
        wait_ph(4'h1, n);
        check(n >= 40 && n <= 48, 1);
        low_sup = 1'b1;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            n++;
            @(negedge clk_in);
        end
        check(n >= 900 && n <= 910, 1);
        wait_ph(4'h0, n);
        check(n >= 95 && n <= 105, 1);
        low_sup = 1'b0;
        wait_ph(4'h1, n);
        check(n >= 40 && n <= 48, 1);
        check(faddr, 12'h000);
    endtask : t_resets

    // ********************************************************************
    // Main sequence and watchdog
    // ********************************************************************
    initial begin
        {nrst_in, osc_slow, halt, wake, clk_stop, s2n, branch, alu_en} = 8'h00;
        {low_sup, ext_n, swr, target, operand} = {3'b010, 12'h000, 8'h00};
        op = ALU_ADD;
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        wait_ph(4'h1, n);
        check(n >= 40 && n <= 48, 1);
        check(faddr, 12'h000);
        t_pipe();
        t_alu_branch();
        t_halt(1'b0, 1'b0, 1'b0, 2);
        t_halt(1'b0, 1'b1, 1'b0, 1024);
        t_halt(1'b0, 1'b1, 1'b1, 2);
        t_halt(1'b1, 1'b0, 1'b0, 1024);
        t_resets();
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        final_report();
    end
endmodule : tb_mcu_fetch_execute_timing
